//--- egress_decide.sv
// Combinational forwarding, untag and two-queue decision for one looked-up frame.
// Assumes the caller registers the result and supplies the entry read for the frame's VLAN.
`timescale 1ns/1ps
module egress_decide (
    input switch_vlan_pkg::vlan_entry_t entry,
    input switch_vlan_pkg::frame_req_t frame,
    input logic two_queue_mode,
    input logic [1:0] two_queue_priority_map,
    input logic unicast_restrict,
    output switch_vlan_pkg::frame_res_t result
);

    function automatic logic high_q(input logic [1:0] code, input logic [1:0] prio);
        case (code)
            switch_vlan_pkg::QMAP_TOP_HIGH: return prio == 2'h3;
            switch_vlan_pkg::QMAP_UPPER_HIGH: return prio >= 2'h2;
            switch_vlan_pkg::QMAP_ALL_BUT_ZERO: return prio != 2'h0;
            // The unused code behaves like the reset mapping so nothing depends on it.
            default: return prio >= 2'h2;
        endcase
    endfunction

    wire logic [6:0] base_map;
    wire logic single;
    wire logic mirror_drop;
    wire logic limit;
    wire logic [6:0] limited;
    wire logic drop;

    assign base_map = entry.forward_override_bit ? entry.fwd_map : frame.other_map;
    assign single = switch_vlan_pkg::one_port(base_map);
    assign mirror_drop = !unicast_restrict && single && frame.mirror_active && frame.mirrored;
    assign limit = unicast_restrict || !single;
    assign limited = limit ? (base_map & frame.member_map) : base_map;
    assign drop = !entry.valid || mirror_drop;

    assign result.entry_valid = entry.valid;
    assign result.dropped = drop;
    assign result.fwd_map = drop ? 7'h00 : limited;
    assign result.untag_map = entry.valid ? entry.untag_map : 7'h00;
    assign result.filter_id = entry.filter_id;
    assign result.priority_level = entry.priority_level;
    assign result.spanning_tree_instance = entry.spanning_tree_instance;
    assign result.high_queue = two_queue_mode
        && high_q(two_queue_priority_map, frame.regen_prio);

endmodule

//--- mgmt_host.sv
// Host model for the management register port: word reads, writes and table actions.
// Assumes a registered acknowledge one cycle after each one-cycle strobe.
`timescale 1ns/1ps
module mgmt_host (
    input wire logic clk,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_addr,
    output logic [31:0] reg_wdata
);
    // ************************************************************
    // Register accesses
    // ************************************************************
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 32'h00000000;
    end

    // Address and data are inverted once released, so a stale bus value never looks valid.
    task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic ok);
        @(posedge clk);
        #1;
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        q = reg_rdata;
        ok = (reg_ack === 1'b1);
    endtask

    // Starts a table action, then polls the start bit a bounded number of times.
    task automatic run_action(input logic [1:0] act, input logic [11:0] idx, output logic ok);
        logic [31:0] q;
        logic a;
        access(1'b1, switch_vlan_pkg::INDEX_ADDR, {8'h00, 1'b1, 5'h00, act, 4'h0, idx}, q, a);
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            access(1'b0, switch_vlan_pkg::INDEX_ADDR, 32'h00000000, q, a);
            ok = a && (q[switch_vlan_pkg::START_BIT] === 1'b0);
        end
    endtask
endmodule

//--- switch_queue_vlan_entry_regs.sv
// Queue control and VLAN entry staging registers, the VLAN table and its actions,
// and the per-frame lookup that applies the table. Assumes the register port and
// lookup requests come from logic on clk; nrst may be asynchronous.
//
// Behaviour
// - Two-queue mode maps priority via two-bit selector.
// - Selector codes pick low/high split; 01 unused.
// - Restrict bit set limits frames to member ports.
// - Restrict clear leaves single-destination frames unlimited.
// - Unrestricted mirrored single-destination frames are dropped.
// - Entry usable only when valid bit set.
// - Override set forwards to entry's port map.
// - Override clear uses lookup-derived forwarding ports.
// - Entry holds three-bit priority, reset zero.
// - Entry holds three-bit spanning tree instance.
// - Entry holds seven-bit filter ID for hashing.
// - Entry untag map strips tags per port.
// - Word two forward map applies under override.
// - Start bit runs action, self-clears when done.
`timescale 1ns/1ps
module switch_queue_vlan_entry_regs #(
    parameter int IDX_W = 12
) (
    input logic clk,
    input logic nrst,
    input logic reg_wr,
    input logic reg_rd,
    input logic [15:0] reg_addr,
    input logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    input logic two_queue_mode,
    input logic lookup_req,
    input switch_vlan_pkg::frame_req_t frame,
    output logic lookup_done,
    output switch_vlan_pkg::frame_res_t result,
    output logic table_busy
);

    localparam int DEPTH = 1 << IDX_W;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_CLEAR = 3'b100
    } table_state_t;

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rst_sync_q;
    wire logic rst_n;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ************************************************************
    // Register state and decode
    // ************************************************************
    logic [7:0] qctrl_q;
    switch_vlan_pkg::vlan_entry_t stage_q;
    logic [11:0] index_q;
    switch_vlan_pkg::table_action_t action_q;
    table_state_t state_q;
    logic [IDX_W-1:0] clr_q;
    logic [31:0] rdata_q;
    logic ack_q;
    switch_vlan_pkg::frame_res_t result_q;
    logic done_q;
    switch_vlan_pkg::vlan_entry_t table_q [DEPTH];

    wire logic idle;
    wire logic wr_qctrl;
    wire logic wr_e0;
    wire logic wr_e1;
    wire logic wr_e2;
    wire logic wr_idx;
    wire logic start_ok;
    wire switch_vlan_pkg::table_action_t wr_action;
    wire switch_vlan_pkg::vlan_entry_t stage_wr;
    wire logic load_read;
    wire logic tbl_we;
    wire logic [IDX_W-1:0] tbl_addr;
    wire switch_vlan_pkg::vlan_entry_t tbl_wdata;
    wire logic [31:0] rd_word;
    wire switch_vlan_pkg::vlan_entry_t look_entry;
    wire switch_vlan_pkg::frame_res_t dec_res;

    assign idle = state_q == ST_IDLE;
    assign wr_qctrl = reg_wr && reg_addr == switch_vlan_pkg::QUEUE_CTRL_ADDR;
    // Staging writes are refused while an action runs so a table write stores what was staged.
    assign wr_e0 = reg_wr && idle && reg_addr == switch_vlan_pkg::ENTRY0_ADDR;
    assign wr_e1 = reg_wr && idle && reg_addr == switch_vlan_pkg::ENTRY1_ADDR;
    assign wr_e2 = reg_wr && idle && reg_addr == switch_vlan_pkg::ENTRY2_ADDR;
    assign wr_idx = reg_wr && idle && reg_addr == switch_vlan_pkg::INDEX_ADDR;
    assign wr_action = switch_vlan_pkg::table_action_t'(
        reg_wdata[switch_vlan_pkg::ACT_HI:switch_vlan_pkg::ACT_LO]);
    assign start_ok = wr_idx && reg_wdata[switch_vlan_pkg::START_BIT];
    assign load_read = state_q == ST_RUN && action_q == switch_vlan_pkg::ACT_READ;

    function automatic switch_vlan_pkg::vlan_entry_t merge_entry(
        input switch_vlan_pkg::vlan_entry_t e, input logic [31:0] d,
        input logic w0, input logic w1, input logic w2);
        switch_vlan_pkg::vlan_entry_t r;
        r = e;
        if (w0) begin
            r.valid = d[switch_vlan_pkg::VALID_BIT];
            r.forward_override_bit = d[switch_vlan_pkg::FO_BIT];
            r.priority_level = d[switch_vlan_pkg::PRIO_HI:switch_vlan_pkg::PRIO_LO];
            r.spanning_tree_instance = d[switch_vlan_pkg::MSTI_HI:switch_vlan_pkg::MSTI_LO];
            r.filter_id = d[switch_vlan_pkg::FID_HI:0];
        end
        if (w1) begin
            r.untag_map = d[switch_vlan_pkg::MAP_HI:0];
        end
        if (w2) begin
            r.fwd_map = d[switch_vlan_pkg::MAP_HI:0];
        end
        return r;
    endfunction

    // Reserved positions stay zero in the entry and index readback words.
    function automatic logic [31:0] word0(input switch_vlan_pkg::vlan_entry_t e);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[switch_vlan_pkg::VALID_BIT] = e.valid;
        w[switch_vlan_pkg::FO_BIT] = e.forward_override_bit;
        w[switch_vlan_pkg::PRIO_HI:switch_vlan_pkg::PRIO_LO] = e.priority_level;
        w[switch_vlan_pkg::MSTI_HI:switch_vlan_pkg::MSTI_LO] = e.spanning_tree_instance;
        w[switch_vlan_pkg::FID_HI:0] = e.filter_id;
        return w;
    endfunction

    function automatic logic [31:0] map_word(input logic [6:0] m);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[switch_vlan_pkg::MAP_HI:0] = m;
        return w;
    endfunction

    function automatic logic [31:0] index_word(input logic [11:0] idx,
        input logic [1:0] act, input logic busy);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[switch_vlan_pkg::INDEX_HI:0] = idx;
        w[switch_vlan_pkg::ACT_HI:switch_vlan_pkg::ACT_LO] = act;
        w[switch_vlan_pkg::START_BIT] = busy;
        return w;
    endfunction

    assign stage_wr = merge_entry(stage_q, reg_wdata, wr_e0, wr_e1, wr_e2);
    assign rd_word = (reg_addr == switch_vlan_pkg::QUEUE_CTRL_ADDR) ? {24'h000000, qctrl_q}
        : (reg_addr == switch_vlan_pkg::ENTRY0_ADDR) ? word0(stage_q)
        : (reg_addr == switch_vlan_pkg::ENTRY1_ADDR) ? map_word(stage_q.untag_map)
        : (reg_addr == switch_vlan_pkg::ENTRY2_ADDR) ? map_word(stage_q.fwd_map)
        : (reg_addr == switch_vlan_pkg::INDEX_ADDR) ? index_word(index_q, action_q, !idle)
        : 32'h0000_0000;

    // ************************************************************
    // Register file
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qctrl_q <= switch_vlan_pkg::QCTRL_RESET;
            stage_q <= '0;
            index_q <= 12'h000;
            action_q <= switch_vlan_pkg::ACT_NONE;
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
        end else begin
            if (wr_qctrl) begin
                qctrl_q <= reg_wdata[switch_vlan_pkg::QCTRL_HI:0];
            end
            stage_q <= load_read ? table_q[index_q[IDX_W-1:0]] : stage_wr;
            if (wr_idx) begin
                index_q <= reg_wdata[switch_vlan_pkg::INDEX_HI:0];
                action_q <= wr_action;
            end
            if (reg_rd) begin
                rdata_q <= rd_word;
            end
            ack_q <= reg_rd || reg_wr;
        end
    end

    // ************************************************************
    // Table actions
    // ************************************************************
    // Clearing walks every entry, one per cycle; the start bit reads one until the last.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            clr_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    clr_q <= '0;
                    if (start_ok) begin
                        state_q <= (wr_action == switch_vlan_pkg::ACT_CLEAR) ? ST_CLEAR : ST_RUN;
                    end
                end
                ST_RUN: state_q <= ST_IDLE;
                ST_CLEAR: begin
                    clr_q <= IDX_W'(clr_q + 1'b1);
                    if (&clr_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign tbl_we = (state_q == ST_RUN && action_q == switch_vlan_pkg::ACT_WRITE)
        || state_q == ST_CLEAR;
    assign tbl_addr = (state_q == ST_CLEAR) ? clr_q : index_q[IDX_W-1:0];
    assign tbl_wdata = (state_q == ST_CLEAR) ? '0 : stage_q;

    // The table has no reset; software runs a clear action before trusting lookups.
    always_ff @(posedge clk) begin
        if (tbl_we) begin
            table_q[tbl_addr] <= tbl_wdata;
        end
    end

    // ************************************************************
    // Frame lookup
    // ************************************************************
    assign look_entry = table_q[frame.vid[IDX_W-1:0]];

    egress_decide u_decide (
        .entry(look_entry),
        .frame(frame),
        .two_queue_mode(two_queue_mode),
        .two_queue_priority_map(qctrl_q[switch_vlan_pkg::QMAP_HI:switch_vlan_pkg::QMAP_LO]),
        .unicast_restrict(qctrl_q[switch_vlan_pkg::RESTRICT_BIT]),
        .result(dec_res)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= '0;
            done_q <= 1'b0;
        end else begin
            if (lookup_req) begin
                result_q <= dec_res;
            end
            done_q <= lookup_req;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_ack = ack_q;
    assign lookup_done = done_q;
    assign result = result_q;
    assign table_busy = !idle;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire logic [1:0] req_prio = frame.regen_prio;
    wire logic [6:0] req_member = frame.member_map;
    wire logic [6:0] req_base = look_entry.forward_override_bit ? look_entry.fwd_map
        : frame.other_map;
    wire logic restrict_h = qctrl_q[switch_vlan_pkg::RESTRICT_BIT];
    wire logic [2:0] wr_prio = reg_wdata[switch_vlan_pkg::PRIO_HI:switch_vlan_pkg::PRIO_LO];

    sequence busy_one_cycle;
        table_busy ##1 !table_busy;
    endsequence

    queue_low_a: assert property (lookup_req && two_queue_mode && req_prio == 2'h0 |=>
        !result.high_queue) else $error("priority zero not sent to low queue");
    queue_code_a: assert property (lookup_req && two_queue_mode &&
        qctrl_q[switch_vlan_pkg::QMAP_HI:switch_vlan_pkg::QMAP_LO] == 2'h0
        |=> result.high_queue == ($past(req_prio) == 2'h3))
        else $error("selector 00 mapping wrong");
    restrict_a: assert property (lookup_req && restrict_h |=>
        (result.fwd_map & ~$past(req_member)) == 7'h00) else $error("restricted frame leaked");
    single_free_a: assert property (lookup_req && !restrict_h && look_entry.valid &&
        switch_vlan_pkg::one_port(req_base) && !(frame.mirror_active && frame.mirrored)
        |=> result.fwd_map == $past(req_base)) else $error("single destination was limited");
    mirror_drop_a: assert property (lookup_req && !restrict_h && frame.mirror_active &&
        frame.mirrored && switch_vlan_pkg::one_port(req_base)
        |=> result.dropped && result.fwd_map == 7'h00) else $error("mirrored frame not dropped");
    invalid_a: assert property (lookup_req && !look_entry.valid |=>
        !result.entry_valid && result.fwd_map == 7'h00) else $error("invalid entry used");
    override_a: assert property (lookup_req && look_entry.valid && restrict_h &&
        look_entry.forward_override_bit
        |=> result.fwd_map == ($past(look_entry.fwd_map) & $past(req_member)))
        else $error("override map not applied");
    other_map_a: assert property (lookup_req && look_entry.valid && restrict_h &&
        !look_entry.forward_override_bit
        |=> result.fwd_map == ($past(frame.other_map) & $past(req_member)))
        else $error("lookup map not applied");
    prio_store_a: assert property (wr_e0 |=>
        stage_q.priority_level == $past(wr_prio)) else $error("entry priority not stored");
    start_clear_a: assert property (start_ok && wr_action != switch_vlan_pkg::ACT_CLEAR
        |=> busy_one_cycle) else $error("start bit did not self clear");
    clear_busy_a: assert property (start_ok && wr_action == switch_vlan_pkg::ACT_CLEAR
        |=> table_busy [*8]) else $error("clear ended early");
    reserved_a: assert property (reg_rd && reg_addr == switch_vlan_pkg::ENTRY1_ADDR |=>
        reg_rdata[31:7] == 25'h0000000) else $error("reserved bits not zero");

endmodule

//--- switch_vlan_pkg.sv
// Shared constants, field positions and carrier types of the queue and VLAN entry registers.
// Assumes word-wide register accesses at byte addresses on the management register port.
package switch_vlan_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [15:0] QUEUE_CTRL_ADDR = 16'h0390;
    localparam logic [15:0] ENTRY0_ADDR = 16'h0400;
    localparam logic [15:0] ENTRY1_ADDR = 16'h0404;
    localparam logic [15:0] ENTRY2_ADDR = 16'h0408;
    // Index word; the access control byte sits at 0x40E, lane 2 of this word.
    localparam logic [15:0] INDEX_ADDR = 16'h040C;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int QCTRL_HI = 7;
    localparam int QMAP_HI = 7;
    localparam int QMAP_LO = 6;
    localparam int RESTRICT_BIT = 1;
    localparam logic [7:0] QCTRL_RESET = 8'h82;
    localparam int VALID_BIT = 31;
    localparam int FO_BIT = 27;
    localparam int PRIO_HI = 26;
    localparam int PRIO_LO = 24;
    localparam int MSTI_HI = 14;
    localparam int MSTI_LO = 12;
    localparam int FID_HI = 6;
    localparam int MAP_HI = 6;
    localparam int INDEX_HI = 11;
    localparam int START_BIT = 23;
    localparam int ACT_HI = 17;
    localparam int ACT_LO = 16;

    // ************************************************************
    // Encodings
    // ************************************************************
    typedef enum logic [1:0] {
        ACT_NONE = 2'h0,
        ACT_WRITE = 2'h1,
        ACT_READ = 2'h2,
        ACT_CLEAR = 2'h3
    } table_action_t;

    localparam logic [1:0] QMAP_TOP_HIGH = 2'h0;
    localparam logic [1:0] QMAP_UPPER_HIGH = 2'h2;
    localparam logic [1:0] QMAP_ALL_BUT_ZERO = 2'h3;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic forward_override_bit;
        logic [2:0] priority_level;
        logic [2:0] spanning_tree_instance;
        logic [6:0] filter_id;
        logic [6:0] untag_map;
        logic [6:0] fwd_map;
    } vlan_entry_t;

    typedef struct packed {
        logic [11:0] vid;
        logic [1:0] regen_prio;
        logic [6:0] other_map;
        logic [6:0] member_map;
        logic mirror_active;
        logic mirrored;
    } frame_req_t;

    typedef struct packed {
        logic entry_valid;
        logic dropped;
        logic high_queue;
        logic [6:0] fwd_map;
        logic [6:0] untag_map;
        logic [6:0] filter_id;
        logic [2:0] priority_level;
        logic [2:0] spanning_tree_instance;
    } frame_res_t;

    function automatic logic one_port(input logic [6:0] m);
        return (m != 7'h00) && ((m & (m - 7'h01)) == 7'h00);
    endfunction

endpackage

//--- tb.sv
// Self-checking bench for the queue control and VLAN entry registers and the lookup.
// Assumes mgmt_host drives the register port; lookups are driven here.
`timescale 1ns/1ps
module tb;
    // ************************************************************
    // Signals, clock and instances
    // ************************************************************
    logic clk, nrst, reg_wr, reg_rd, reg_ack, two_queue_mode, lookup_req, lookup_done, table_busy;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    switch_vlan_pkg::frame_req_t frame;
    switch_vlan_pkg::frame_res_t result;
    int err_count = 0;
    int tests_run = 0;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    mgmt_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    // A small table keeps the clear action short.
    switch_queue_vlan_entry_regs #(.IDX_W(4)) dut (.clk(clk), .nrst(nrst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .two_queue_mode(two_queue_mode), .lookup_req(lookup_req),
        .frame(frame), .lookup_done(lookup_done), .result(result), .table_busy(table_busy));

    // ************************************************************
    // Checking helpers
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A poll that runs out of tries is a hang, so the run closes at once.
    task automatic act(input logic [1:0] a, input logic [11:0] idx);
        logic ok;
        host.run_action(a, idx, ok);
        check({31'h0, ok}, 32'h1);
        if (!ok) begin
            give_verdict();
        end
    endtask

    function automatic switch_vlan_pkg::frame_res_t expect_res(
        input switch_vlan_pkg::vlan_entry_t e, input switch_vlan_pkg::frame_req_t f,
        input logic tq, input logic [1:0] m, input logic rs);
        switch_vlan_pkg::frame_res_t r;
        logic [6:0] base;
        base = e.forward_override_bit ? e.fwd_map : f.other_map;
        r = '0;
        r.entry_valid = e.valid;
        r.untag_map = e.untag_map;
        r.filter_id = e.filter_id;
        r.priority_level = e.priority_level;
        r.spanning_tree_instance = e.spanning_tree_instance;
        if (!e.valid) begin
            r.dropped = 1'b1;
            r.untag_map = 7'h00;
        end else if (rs || $countones(base) != 1) begin
            r.fwd_map = base & f.member_map;
        end else if (f.mirror_active && f.mirrored) begin
            r.dropped = 1'b1;
        end else begin
            r.fwd_map = base;
        end
        if (tq) begin
            r.high_queue = (m == 2'h0) ? (f.regen_prio == 2'h3) :
                           (m == 2'h3) ? (f.regen_prio != 2'h0) : f.regen_prio[1];
        end
        return r;
    endfunction

    task automatic check_lookup(input switch_vlan_pkg::vlan_entry_t e,
        input switch_vlan_pkg::frame_req_t f, input logic tq, input logic [1:0] m, input logic rs);
        switch_vlan_pkg::frame_res_t x;
        x = expect_res(e, f, tq, m, rs);
        @(posedge clk);
        #1;
        frame = f;
        two_queue_mode = tq;
        lookup_req = 1'b1;
        @(posedge clk);
        #1;
        lookup_req = 1'b0;
        frame = ~f;
        check({31'h0, lookup_done}, 32'h1);
        if (e.valid) begin
            check({1'b0, result}, {1'b0, x});
        end else begin
            check({16'h0, result.entry_valid, result.dropped, result.fwd_map, result.untag_map},
                  {16'h0, x.entry_valid, x.dropped, x.fwd_map, x.untag_map});
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [31:0] q, rv, w0;
        logic ok;
        logic [3:0] idx;
        switch_vlan_pkg::vlan_entry_t e;
        switch_vlan_pkg::frame_req_t f;
        void'($urandom(32'hd321));
        nrst = 1'b0;
        two_queue_mode = 1'b0;
        lookup_req = 1'b0;
        frame = '0;
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clk);
        host.access(1'b0, switch_vlan_pkg::QUEUE_CTRL_ADDR, 32'h0, q, ok);
        check(q, 32'h00000082);
        host.access(1'b0, switch_vlan_pkg::ENTRY0_ADDR, 32'h0, q, ok);
        check(q, 32'h00000000);
        host.access(1'b0, switch_vlan_pkg::ENTRY1_ADDR, 32'h0, q, ok);
        check(q, 32'h00000000);
        host.access(1'b0, 16'h03FC, 32'h0, q, ok);
        check(q, 32'h00000000);
        host.access(1'b1, switch_vlan_pkg::INDEX_ADDR, 32'h0083_0000, q, ok);
        host.access(1'b1, switch_vlan_pkg::ENTRY1_ADDR, 32'h0000_007F, q, ok);
        check({31'h0, table_busy}, 32'h1);
        // This start lands while the first clear still runs, so only its polling counts.
        act(switch_vlan_pkg::ACT_CLEAR, 12'h000);
        host.access(1'b0, switch_vlan_pkg::ENTRY1_ADDR, 32'h0, q, ok);
        check(q, 32'h00000000);
        act(switch_vlan_pkg::ACT_NONE, 12'h003);
        check({31'h0, table_busy}, 32'h0);
        f = '0;
        f.vid = 12'h005;
        check_lookup('0, f, 1'b1, 2'h2, 1'b1);
        for (int i = 0; i < 40; i++) begin
            rv = $urandom;
            e = rv[28:0];
            e.valid = (rv[31:30] != 2'h0);
            if (rv[29]) begin
                e.fwd_map = 7'h01 << $urandom_range(6, 0);
            end
            idx = 4'($urandom_range(15, 0));
            w0 = {e.valid, 3'h0, e.forward_override_bit, e.priority_level, 9'h000,
                  e.spanning_tree_instance, 5'h00, e.filter_id};
            host.access(1'b1, switch_vlan_pkg::ENTRY0_ADDR, w0 | 32'h70FF8F80, q, ok);
            host.access(1'b1, switch_vlan_pkg::ENTRY1_ADDR, {25'h1FFFFFF, e.untag_map}, q, ok);
            host.access(1'b1, switch_vlan_pkg::ENTRY2_ADDR, {25'h1FFFFFF, e.fwd_map}, q, ok);
            host.access(1'b0, switch_vlan_pkg::ENTRY1_ADDR, 32'h0, q, ok);
            check(q, {25'h0, e.untag_map});
            act(switch_vlan_pkg::ACT_WRITE, {8'h00, idx});
            host.access(1'b1, switch_vlan_pkg::ENTRY0_ADDR, 32'h0, q, ok);
            act(switch_vlan_pkg::ACT_READ, {8'h00, idx});
            host.access(1'b0, switch_vlan_pkg::ENTRY0_ADDR, 32'h0, q, ok);
            check(q, w0);
            rv = $urandom;
            rv[7:6] = 2'(i);
            rv[1] = (i % 8) < 4;
            host.access(1'b1, switch_vlan_pkg::QUEUE_CTRL_ADDR, rv, q, ok);
            host.access(1'b0, switch_vlan_pkg::QUEUE_CTRL_ADDR, 32'h0, q, ok);
            check(q, {24'h0, rv[7:0]});
            f = 30'($urandom);
            f.vid = {8'h00, idx};
            if (i % 2 == 0) begin
                f.other_map = 7'h01 << $urandom_range(6, 0);
            end
            check_lookup(e, f, (i % 5) != 0, rv[7:6], rv[1]);
        end
        give_verdict();
    end
endmodule
